// ### shared/coc_pkg.sv
// constants for the charge option low byte block
// assumes a 25 MHz device clock and a register write port fed by the host bus decoder
package coc_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] CHARGE_OPTION_LOW_BYTE_OFFSET = 8'h01;
    localparam logic [7:0] CHARGE_OPTION_LOW_BYTE_RESET  = 8'he7;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int LOW_POWER_ENABLE_BIT      = 7;
    localparam int WATCHDOG_PERIOD_LSB       = 5;
    localparam int INPUT_LIMIT_AUTO_OFF_BIT  = 4;
    localparam int OTG_FORCES_SUPPLY_BIT     = 3;
    localparam int OUT_OF_AUDIO_BIT          = 2;
    localparam int SWITCHING_FREQ_BIT        = 1;
    localparam int BATTERY_OVP_BIT           = 0;

    // ****************************************************************
    // watchdog timing
    // ****************************************************************
    localparam int CLK_HZ           = 25_000_000;
    localparam int TICK_MS          = 1;
    localparam int TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;
    localparam int WD_5S_MS         = 5_000;
    localparam int WD_88S_MS        = 88_000;
    localparam int WD_175S_MS       = 175_000;
    localparam int WD_COUNT_W       = 18;

    typedef enum logic [1:0]
    {
        COC_WD_OFF  = 2'b00,
        COC_WD_5S   = 2'b01,
        COC_WD_88S  = 2'b10,
        COC_WD_175S = 2'b11
    } coc_wd_period_t;

endpackage

// ### verilog/coc_watchdog_timer.sv
// watchdog timer counting millisecond ticks up to the selected period
// assumes restart is a one-cycle pulse from the owning register block
`timescale 1ns/1ns
module coc_watchdog_timer
#(
    parameter int TICK_CYCLES = coc_pkg::TICK_CYCLES
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // control
    input  wire logic [1:0] period_sel,
    input  wire logic       restart,
    // result
    output logic            expired
);

    typedef struct packed
    {
        logic [31:0]                   prescale;
        logic [coc_pkg::WD_COUNT_W-1:0] ms_count;
        logic                          expired;
    } coc_wd_state_t;

    coc_wd_state_t state;
    coc_wd_state_t next_state;
    logic [coc_pkg::WD_COUNT_W-1:0] limit;

    always_comb
    begin
        case (coc_pkg::coc_wd_period_t'(period_sel))
            coc_pkg::COC_WD_5S:   limit = coc_pkg::WD_COUNT_W'(coc_pkg::WD_5S_MS);
            coc_pkg::COC_WD_88S:  limit = coc_pkg::WD_COUNT_W'(coc_pkg::WD_88S_MS);
            coc_pkg::COC_WD_175S: limit = coc_pkg::WD_COUNT_W'(coc_pkg::WD_175S_MS);
            default:              limit = '0;
        endcase
    end

    always_comb
    begin
        next_state = state;
        if (restart || period_sel == 2'b00)
        begin
            // restart clears expiry; a disabled timer holds idle
            next_state.prescale = '0;
            next_state.ms_count = '0;
            next_state.expired  = 1'b0;
        end
        else if (!state.expired)
        begin
            if (state.prescale == 32'(TICK_CYCLES - 1))
            begin
                next_state.prescale = '0;
                next_state.ms_count = state.ms_count + 1'b1;
                // no qualifying write inside the period
                if (state.ms_count + 1'b1 >= limit)
                begin
                    next_state.expired = 1'b1;
                end
            end
            else
            begin
                next_state.prescale = state.prescale + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign expired = state.expired;

endmodule

// ### verilog/coc_charge_option.sv
// charge option low byte: register, low power gating, watchdog, input limit auto-off
// assumes the host bus decoder presents one-cycle write and read strobes with a byte address
`timescale 1ns/1ns
module coc_charge_option
#(
    parameter int TICK_CYCLES = coc_pkg::TICK_CYCLES
)
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       register_reset,
    // register port from the host bus decoder
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_write,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    // watchdog sources
    input  wire logic       charge_voltage_write,
    input  wire logic       charge_current_write,
    input  wire logic       watchdog_restart,
    // operating state
    input  wire logic       battery_only,
    input  wire logic       otg_mode,
    input  wire logic       battery_present_pin,
    input  wire logic       high_impedance_state,
    // settings owned by other registers
    input  wire logic       processor_hot_alert_cfg,
    input  wire logic       adapter_current_monitor_cfg,
    input  wire logic       battery_current_monitor_cfg,
    input  wire logic       system_power_monitor_cfg,
    input  wire logic       comparator_cfg,
    input  wire logic       low_power_comparator_enable,
    input  wire logic       low_power_regulator_enable,
    // function enables, all but the adapter monitor set by low power; comparator and regulator then follow their low power enables
    output logic            processor_hot_alert_en,
    output logic            adapter_current_monitor_en,
    output logic            battery_current_monitor_en,
    output logic            system_power_monitor_en,
    output logic            comparator_en,
    output logic            converter_available,
    output logic            internal_regulator_output_en,
    output logic            internal_regulator_low_current,
    // charge and loop control
    output logic            charge_current_force_zero,
    output logic            input_limit_loop_clear,
    output logic            supply_good_force_high,
    output logic            switching_freq_select,
    output logic            out_of_audio_enable,
    output logic            battery_ovp_enable
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed
    {
        logic [7:0] option;
        logic [7:0] rdata;
        logic       alert_en;
        logic       adapter_mon_en;
        logic       battery_mon_en;
        logic       power_mon_en;
        logic       cmp_en;
        logic       conv_avail;
        logic       reg_en;
        logic       reg_low;
        logic       force_zero;
        logic       limit_clear;
        logic       supply_high;
        logic       freq_active;
        logic       ooa_en;
        logic       ovp_en;
    } coc_state_t;

    localparam coc_state_t COC_RESET_STATE = '{
        option:      coc_pkg::CHARGE_OPTION_LOW_BYTE_RESET,
        rdata:       8'h00,
        alert_en:    1'b0,
        adapter_mon_en: 1'b0,
        battery_mon_en: 1'b0,
        power_mon_en: 1'b0,
        cmp_en:      1'b0,
        conv_avail:  1'b0,
        reg_en:      1'b0,
        reg_low:     1'b0,
        force_zero:  1'b0,
        limit_clear: 1'b0,
        supply_high: 1'b0,
        freq_active: coc_pkg::CHARGE_OPTION_LOW_BYTE_RESET[coc_pkg::SWITCHING_FREQ_BIT],
        ooa_en:      coc_pkg::CHARGE_OPTION_LOW_BYTE_RESET[coc_pkg::OUT_OF_AUDIO_BIT],
        ovp_en:      coc_pkg::CHARGE_OPTION_LOW_BYTE_RESET[coc_pkg::BATTERY_OVP_BIT]
    };

    coc_state_t state;
    coc_state_t next_state;

    logic       option_hit;
    logic       wd_restart;
    logic       wd_expired;
    logic       low_power;
    logic [7:0] opt;

    // ****************************************************************
    // watchdog
    // ****************************************************************
    assign option_hit = (reg_addr == coc_pkg::CHARGE_OPTION_LOW_BYTE_OFFSET);
    // a byte write always carries the period field, so it counts as a period write
    assign wd_restart = charge_voltage_write || charge_current_write
                     || (reg_write && option_hit) || watchdog_restart;

    coc_watchdog_timer
    #(
        .TICK_CYCLES (TICK_CYCLES)
    )
    u_watchdog
    (
        .clk        (clk),
        .reset_n    (reset_n),
        .period_sel (state.option[coc_pkg::WATCHDOG_PERIOD_LSB +: 2]),
        .restart    (wd_restart),
        .expired    (wd_expired)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    assign opt       = state.option;
    assign low_power = opt[coc_pkg::LOW_POWER_ENABLE_BIT] && battery_only;

    always_comb
    begin
        next_state = state;

        if (register_reset)
        begin
            next_state.option = coc_pkg::CHARGE_OPTION_LOW_BYTE_RESET;
        end
        else if (reg_write && option_hit)
        begin
            next_state.option = reg_wdata;
        end

        if (reg_read)
        begin
            next_state.rdata = option_hit ? opt : 8'h00;
        end

        if (low_power)
        begin
            next_state.alert_en       = 1'b0;
            next_state.battery_mon_en = 1'b0;
            next_state.power_mon_en   = 1'b0;
            next_state.conv_avail     = 1'b0;
            next_state.cmp_en         = low_power_comparator_enable;
            next_state.reg_en         = low_power_regulator_enable;
            next_state.reg_low        = 1'b1;
        end
        else
        begin
            next_state.alert_en       = processor_hot_alert_cfg;
            next_state.battery_mon_en = battery_current_monitor_cfg;
            next_state.power_mon_en   = system_power_monitor_cfg;
            next_state.conv_avail     = 1'b1;
            next_state.cmp_en         = comparator_cfg;
            next_state.reg_en         = 1'b1;
            next_state.reg_low        = 1'b0;
        end
        // adapter monitor is not among the buffers that low power shuts off
        next_state.adapter_mon_en = adapter_current_monitor_cfg;

        // held until a restart source arrives
        next_state.force_zero  = wd_expired && !wd_restart;

        // level, so a host re-enable sticks only once the battery is back
        next_state.limit_clear = opt[coc_pkg::INPUT_LIMIT_AUTO_OFF_BIT] && !battery_present_pin;

        next_state.supply_high = opt[coc_pkg::OTG_FORCES_SUPPLY_BIT] && otg_mode;

        // changing frequency while switching would upset the loop
        if (high_impedance_state)
        begin
            next_state.freq_active = opt[coc_pkg::SWITCHING_FREQ_BIT];
        end

        next_state.ooa_en = opt[coc_pkg::OUT_OF_AUDIO_BIT];
        next_state.ovp_en = opt[coc_pkg::BATTERY_OVP_BIT];
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= COC_RESET_STATE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata                      = state.rdata;
    assign processor_hot_alert_en         = state.alert_en;
    assign adapter_current_monitor_en     = state.adapter_mon_en;
    assign battery_current_monitor_en     = state.battery_mon_en;
    assign system_power_monitor_en        = state.power_mon_en;
    assign comparator_en                  = state.cmp_en;
    assign converter_available            = state.conv_avail;
    assign internal_regulator_output_en   = state.reg_en;
    assign internal_regulator_low_current = state.reg_low;
    assign charge_current_force_zero      = state.force_zero;
    assign input_limit_loop_clear         = state.limit_clear;
    assign supply_good_force_high         = state.supply_high;
    assign switching_freq_select          = state.freq_active;
    assign out_of_audio_enable            = state.ooa_en;
    assign battery_ovp_enable             = state.ovp_en;

endmodule

// ### tb/coc_charge_option_props.sv
// checker for the charge option low byte block
// assumes it is bound to coc_charge_option and sees only its ports
`timescale 1ns/1ns
module coc_charge_option_props
#(
    parameter int TICK_CYCLES = coc_pkg::TICK_CYCLES
)
(
    // clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    input wire logic       register_reset,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_write,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    // watchdog sources and state
    input wire logic       charge_voltage_write,
    input wire logic       charge_current_write,
    input wire logic       watchdog_restart,
    input wire logic       battery_only,
    input wire logic       otg_mode,
    input wire logic       battery_present_pin,
    input wire logic       high_impedance_state,
    input wire logic       processor_hot_alert_cfg,
    input wire logic       low_power_comparator_enable,
    input wire logic       low_power_regulator_enable,
    // outputs watched
    input wire logic       processor_hot_alert_en,
    input wire logic       battery_current_monitor_en,
    input wire logic       system_power_monitor_en,
    input wire logic       comparator_en,
    input wire logic       converter_available,
    input wire logic       internal_regulator_output_en,
    input wire logic       internal_regulator_low_current,
    input wire logic       charge_current_force_zero,
    input wire logic       input_limit_loop_clear,
    input wire logic       supply_good_force_high,
    input wire logic       switching_freq_select,
    input wire logic       out_of_audio_enable,
    input wire logic       battery_ovp_enable
);
    logic [7:0] sh;
    logic       lp;
    logic       wd_kick;
    // shadow of the byte; outputs lag it by one edge
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            sh <= 8'he7;
        else if (register_reset)
            sh <= 8'he7;
        else if (reg_write && reg_addr == 8'h01)
            sh <= reg_wdata;
    end
    assign lp = sh[7] & battery_only;
    assign wd_kick = charge_voltage_write | charge_current_write | watchdog_restart
                   | (reg_write && reg_addr == 8'h01);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_read_other: assert property (
        reg_read && reg_addr != 8'h01 |=> reg_rdata == 8'h00) else $error("bad other read");
    a_read_back: assert property (
        reg_read && reg_addr == 8'h01 |=> reg_rdata == $past(sh)) else $error("bad readback");
    a_low_power_off: assert property (
        $past(lp) |-> !processor_hot_alert_en && !battery_current_monitor_en
        && !system_power_monitor_en && !converter_available) else $error("low power leak");
    // first edge after release still shows the reset values, not performance mode
    a_perf_mode: assert property (
        $past(reset_n) && !$past(lp)
        |-> processor_hot_alert_en == $past(processor_hot_alert_cfg)
        && converter_available && internal_regulator_output_en) else $error("bad perf mode");
    a_lp_own_bits: assert property (
        $past(lp) |-> comparator_en == $past(low_power_comparator_enable)
        && internal_regulator_output_en == $past(low_power_regulator_enable)
        && internal_regulator_low_current) else $error("bad low power enables");
    a_wd_restart: assert property (
        wd_kick |-> ##2 !charge_current_force_zero) else $error("no restart");
    a_wd_idle: assert property (
        (sh[6:5] == 2'b00) [*3] |-> !charge_current_force_zero) else $error("idle expiry");
    a_auto_off: assert property (
        input_limit_loop_clear == $past(sh[4] & !battery_present_pin)) else $error("bad clear");
    a_otg_good: assert property (
        supply_good_force_high == $past(sh[3] & otg_mode)) else $error("bad supply good");
    a_freq_hold: assert property (
        !$past(high_impedance_state) |-> $stable(switching_freq_select)) else $error("freq moved");
    a_freq_take: assert property (
        $past(high_impedance_state) |-> switching_freq_select == $past(sh[1]))
        else $error("freq not taken");
    a_low_bits: assert property (
        out_of_audio_enable == $past(sh[2]) && battery_ovp_enable == $past(sh[0]))
        else $error("bad low bits");
    c_low_power: cover property (lp);
    c_expiry: cover property ($rose(charge_current_force_zero));
    c_auto_off: cover property (input_limit_loop_clear);
endmodule
bind coc_charge_option coc_charge_option_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.*);

// ### tb/coc_host_model.sv
// host controller model: register accesses and watchdog keep-alive strobes
// assumes the block samples on the rising edge; all moves here are on the falling edge
`timescale 1ns/1ns
module coc_host_model
(
    // clock and read data
    input  wire logic       clk,
    input  wire logic [7:0] reg_rdata,
    // register port
    output logic      [7:0] reg_addr,
    output logic            reg_write,
    output logic      [7:0] reg_wdata,
    output logic            reg_read,
    // watchdog sources
    output logic            charge_voltage_write,
    output logic            charge_current_write,
    output logic            watchdog_restart
);
    initial
    begin
        {reg_addr, reg_write, reg_wdata, reg_read} = '0;
        {charge_voltage_write, charge_current_write, watchdog_restart} = '0;
    end
    // released data is inverted so stale bytes never pass for fresh ones
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk);
        {reg_addr, reg_wdata, reg_write} = {a, v, 1'b1};
        @(negedge clk);
        {reg_wdata, reg_write} = {~v, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk);
        {reg_addr, reg_read} = {a, 1'b1};
        @(negedge clk);
        reg_read = 1'b0;
        v = reg_rdata;
    endtask
    // 0 voltage, 1 current, 2 restart bit; bench spaces them inside the period
    task automatic pulse(input int k);
        @(negedge clk);
        {charge_voltage_write, charge_current_write, watchdog_restart} = 3'b100 >> k;
        @(negedge clk);
        {charge_voltage_write, charge_current_write, watchdog_restart} = 3'b000;
    endtask
endmodule

// ### tb/tb.sv
// self-checking bench for the charge option low byte block
// assumes the host model owns the register port and watchdog strobes
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("BAD %0t got %h want %h", $time, a, e); end end
module tb;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       register_reset = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic       reg_write, reg_read, charge_voltage_write, charge_current_write;
    logic       watchdog_restart, otg_mode = 1'b0, battery_present_pin = 1'b1;
    logic       battery_only = 1'b0, high_impedance_state = 1'b0, processor_hot_alert_cfg = 1'b1;
    logic       adapter_current_monitor_cfg = 1'b1, battery_current_monitor_cfg = 1'b1;
    logic       system_power_monitor_cfg = 1'b1, comparator_cfg = 1'b0;
    logic       low_power_comparator_enable = 1'b1, low_power_regulator_enable = 1'b0;
    logic       processor_hot_alert_en, adapter_current_monitor_en, battery_current_monitor_en;
    logic       system_power_monitor_en, comparator_en, converter_available;
    logic       internal_regulator_output_en, internal_regulator_low_current;
    logic       charge_current_force_zero, input_limit_loop_clear, supply_good_force_high;
    logic       switching_freq_select, out_of_audio_enable, battery_ovp_enable;
    int         n_errors = 0;
    int         total_checks = 0;

    always #20 clk = ~clk;
    // two-cycle tick: the 5 s code expires after about 10000 cycles
    coc_charge_option #(.TICK_CYCLES(2)) u_coc_charge_option (.*);
    coc_host_model u_coc_host_model (.*);

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        u_coc_host_model.rd(a, v);
        `CHK(v, e)
    endtask
    task automatic complete_run;
        if (n_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reg_access;
        rd_chk(8'h01, 8'he7);
        rd_chk(8'h02, 8'h00);
        u_coc_host_model.wr(8'h01, 8'h5a);
        u_coc_host_model.wr(8'h03, 8'hff);
        rd_chk(8'h01, 8'h5a);
        u_coc_host_model.wr(8'h01, 8'ha5);
        rd_chk(8'h01, 8'ha5);
        register_reset = 1'b1;
        cyc(1);
        register_reset = 1'b0;
        rd_chk(8'h01, 8'he7);
    endtask
    task automatic t_low_power;
        battery_only = 1'b1;
        cyc(2);
        `CHK({processor_hot_alert_en, battery_current_monitor_en}, 2'b00)
        `CHK({system_power_monitor_en, converter_available}, 2'b00)
        `CHK({comparator_en, internal_regulator_output_en}, 2'b10)
        `CHK(internal_regulator_low_current, 1'b1)
        `CHK(adapter_current_monitor_en, 1'b1)
        u_coc_host_model.wr(8'h01, 8'h67);
        cyc(2);
        `CHK({processor_hot_alert_en, battery_current_monitor_en}, 2'b11)
        `CHK({system_power_monitor_en, converter_available}, 2'b11)
        `CHK({comparator_en, internal_regulator_output_en}, 2'b01)
        battery_only = 1'b0;
    endtask
    task automatic t_fields;
        otg_mode = 1'b1;
        battery_present_pin = 1'b0;
        u_coc_host_model.wr(8'h01, 8'h18);
        cyc(2);
        `CHK({supply_good_force_high, input_limit_loop_clear}, 2'b11)
        `CHK({switching_freq_select, out_of_audio_enable}, 2'b10)
        {high_impedance_state, otg_mode, battery_present_pin} = 3'b101;
        cyc(2);
        `CHK({supply_good_force_high, input_limit_loop_clear}, 2'b00)
        `CHK(switching_freq_select, 1'b0)
        u_coc_host_model.wr(8'h01, 8'h07);
        cyc(2);
        `CHK({switching_freq_select, out_of_audio_enable}, 2'b11)
        high_impedance_state = 1'b0;
        u_coc_host_model.wr(8'h01, 8'h04);
        cyc(2);
        `CHK({switching_freq_select, battery_ovp_enable}, 2'b10)
    endtask
    task automatic t_watchdog;
        u_coc_host_model.wr(8'h01, 8'h27);
        cyc(9990);
        `CHK(charge_current_force_zero, 1'b0)
        cyc(20);
        `CHK(charge_current_force_zero, 1'b1)
        u_coc_host_model.pulse(2);
        cyc(2);
        `CHK(charge_current_force_zero, 1'b0)
        for (int k = 0; k < 3; k++)
        begin
            cyc(6000);
            `CHK(charge_current_force_zero, 1'b0)
            u_coc_host_model.pulse(k);
        end
        // codes 00 and 10 must both outlast the 5 s span
        u_coc_host_model.wr(8'h01, 8'h07);
        cyc(12000);
        `CHK(charge_current_force_zero, 1'b0)
        u_coc_host_model.wr(8'h01, 8'h47);
        cyc(12000);
        `CHK(charge_current_force_zero, 1'b0)
    endtask

    initial
    begin
        cyc(4);
        reset_n = 1'b1;
        t_reg_access();
        t_low_power();
        t_fields();
        t_watchdog();
        complete_run();
    end
    initial
    begin
        #3_000_000;
        n_errors++;
        complete_run();
    end
endmodule
